/* dccsr_top.sv */
// Output code, calibration, control and status register bank on AXI4-Lite
//
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "dccsr_consts.svh"

module dccsr_top #(
  parameter bit LOW_RES = 1'b0
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // AXI4-Lite write channels
  input wire logic [11:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // AXI4-Lite read channels
  input wire logic [11:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // Reports from engines on this clock
  input wire logic frame_check_fault_i,
  input wire logic watchdog_fault_i,
  input wire logic ramp_active_i,
  // Asynchronous monitor levels and clear pin
  input wire logic current_load_fault_i,
  input wire logic overtemp_fault_i,
  input wire logic clear_level_pin_i,
  // Code towards the converter core
  output logic [15:0] output_code_bits_o,
  output logic [15:0] trimmed_code_o,
  // Output steering
  output logic [2:0] voltage_range_o,
  output logic [1:0] current_range_o,
  output logic both_outputs_enable_o,
  output logic output_enable_o,
  output logic sense_node_pulldown_o,
  // Ramp, trim and supervision controls
  output logic ramp_enable_o,
  output logic [3:0] ramp_clock_select_o,
  output logic [2:0] ramp_step_select_o,
  output logic user_trim_enable_o,
  output logic frame_check_enable_o,
  output logic watchdog_enable_o,
  output logic [1:0] watchdog_period_o,
  output logic soft_reset_o
);

  localparam logic [15:0] DATA_MASK =
    LOW_RES ? `DCCSR_LOW_RES_MASK : `DCCSR_FULL_MASK;

  // Assertion clock and reset for the whole bank
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);

  // Register index decode, shared by write and read paths
  function automatic dccsr_pkg::dccsr_reg_e fn_decode(
    input logic [9:0] idx
  );
    case (idx)
      `DCCSR_IDX_CODE: fn_decode = dccsr_pkg::DCCSR_REG_CODE;
      `DCCSR_IDX_GAIN: fn_decode = dccsr_pkg::DCCSR_REG_GAIN;
      `DCCSR_IDX_ZERO: fn_decode = dccsr_pkg::DCCSR_REG_ZERO;
      `DCCSR_IDX_STAT: fn_decode = dccsr_pkg::DCCSR_REG_STAT;
      `DCCSR_IDX_CTRL: fn_decode = dccsr_pkg::DCCSR_REG_CTRL;
      `DCCSR_IDX_CONF: fn_decode = dccsr_pkg::DCCSR_REG_CONF;
      `DCCSR_IDX_RST: fn_decode = dccsr_pkg::DCCSR_REG_RST;
      default: fn_decode = dccsr_pkg::DCCSR_REG_NONE;
    endcase
  endfunction : fn_decode

  // Byte-lane merge of the low half word
  function automatic logic [15:0] fn_merge(
    input logic [15:0] old,
    input logic [31:0] d,
    input logic [3:0] s
  );
    fn_merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction : fn_merge

  // Clear value: midscale for voltage ranges when selected, else zero
  function automatic logic [15:0] fn_clear(
    input logic [2:0] range,
    input logic sel
  );
    fn_clear = (sel && !range[2]) ? `DCCSR_MIDSCALE : `DCCSR_CODE_RST;
  endfunction : fn_clear

  // Bus state
  logic aw_held_ff;
  logic [9:0] aw_idx_ff;
  logic w_held_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  // Register contents
  logic [15:0] code_ff;
  logic [15:0] gain_ff;
  logic [15:0] zero_ff;
  logic [15:0] ctrl_ff;
  logic [15:0] conf_ff;
  logic [15:0] trimmed_ff;
  logic [1:0] cur_range_ff;
  logic soft_reset_ff;
  // Status flags
  logic crc_flag_ff;
  logic wd_flag_ff;
  logic iload_flag_ff;
  logic ramp_flag_ff;
  logic temp_flag_ff;
  // Synchronisers for asynchronous levels
  logic [2:0] sync1_ff;
  logic [2:0] sync2_ff;

  // Two-flop synchronisers, one per asynchronous input
  wire [2:0] async_in =
    {clear_level_pin_i, current_load_fault_i, overtemp_fault_i};
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      always_ff @(posedge mclk_i) begin
        sync1_ff[gi] <= reset_i ? 1'b0 : async_in[gi];
        sync2_ff[gi] <= reset_i ? 1'b0 : sync1_ff[gi];
      end
    end
  endgenerate
  wire temp_sync = sync2_ff[0];
  wire iload_sync = sync2_ff[1];
  wire clr_pin_sync = sync2_ff[2];

  // Write path decode
  wire wr_do = aw_held_ff && w_held_ff && !bvalid_ff;
  wire dccsr_pkg::dccsr_reg_e wr_sel = fn_decode(aw_idx_ff);
  wire wr_code = wr_do && (wr_sel == dccsr_pkg::DCCSR_REG_CODE);
  wire wr_gain = wr_do && (wr_sel == dccsr_pkg::DCCSR_REG_GAIN);
  wire wr_zero = wr_do && (wr_sel == dccsr_pkg::DCCSR_REG_ZERO);
  wire wr_ctrl = wr_do && (wr_sel == dccsr_pkg::DCCSR_REG_CTRL);
  wire wr_conf = wr_do && (wr_sel == dccsr_pkg::DCCSR_REG_CONF);
  wire wr_rst = wr_do && (wr_sel == dccsr_pkg::DCCSR_REG_RST);
  wire wr_bad = wr_sel == dccsr_pkg::DCCSR_REG_NONE;
  wire soft_req = wr_rst && wstrb_ff[0] &&
    wdata_ff[`DCCSR_RST_BIT];
  wire [15:0] wr_merged_code =
    fn_merge(code_ff, wdata_ff, wstrb_ff) & DATA_MASK;
  wire [15:0] wr_merged_gain =
    fn_merge(gain_ff, wdata_ff, wstrb_ff) & DATA_MASK;
  wire [15:0] wr_merged_zero =
    fn_merge(zero_ff, wdata_ff, wstrb_ff) & DATA_MASK;
  wire [15:0] new_ctrl =
    fn_merge(ctrl_ff, wdata_ff, wstrb_ff) & `DCCSR_CTRL_WMASK;
  wire [15:0] new_conf =
    fn_merge(conf_ff, wdata_ff, wstrb_ff) & `DCCSR_CONF_WMASK;
  wire [2:0] new_range =
    new_ctrl[`DCCSR_CTRL_RANGE_MSB:`DCCSR_CTRL_RANGE_LSB];
  wire [2:0] cur_range =
    ctrl_ff[`DCCSR_CTRL_RANGE_MSB:`DCCSR_CTRL_RANGE_LSB];
  wire range_chg = wr_ctrl && (new_range != cur_range);
  wire clear_level_pin = clr_pin_sync || new_ctrl[`DCCSR_CTRL_CLR_BIT];
  wire [15:0] clear_code = fn_clear(new_range, clear_level_pin) & DATA_MASK;

  // Bus handshakes
  assign s_axi_awready_o = !aw_held_ff;
  assign s_axi_wready_o = !w_held_ff;
  assign s_axi_arready_o = !rvalid_ff;
  assign s_axi_bvalid_o = bvalid_ff;
  assign s_axi_bresp_o = bresp_ff;
  assign s_axi_rvalid_o = rvalid_ff;
  assign s_axi_rdata_o = rdata_ff;
  assign s_axi_rresp_o = rresp_ff;

  // Write address and data are held until both are present
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      aw_held_ff <= 1'b0;
      aw_idx_ff <= 10'h000;
      w_held_ff <= 1'b0;
      wdata_ff <= 32'h00000000;
      wstrb_ff <= 4'h0;
    end else begin
      if (s_axi_awvalid_i && !aw_held_ff) begin
        aw_held_ff <= 1'b1;
        aw_idx_ff <= s_axi_awaddr_i[11:2];
      end else if (wr_do) begin
        aw_held_ff <= 1'b0;
      end
      if (s_axi_wvalid_i && !w_held_ff) begin
        w_held_ff <= 1'b1;
        wdata_ff <= s_axi_wdata_i;
        wstrb_ff <= s_axi_wstrb_i;
      end else if (wr_do) begin
        w_held_ff <= 1'b0;
      end
    end
  end

  // Write response; unmapped indices answer SLVERR
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= `DCCSR_RESP_OKAY;
    end else if (wr_do) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= wr_bad ? `DCCSR_RESP_SLVERR : `DCCSR_RESP_OKAY;
    end else if (s_axi_bready_i) begin
      bvalid_ff <= 1'b0;
    end
  end

  // Read data selection
  wire dccsr_pkg::dccsr_reg_e rd_sel = fn_decode(s_axi_araddr_i[11:2]);
  wire [15:0] status_word = {11'h000, crc_flag_ff, wd_flag_ff,
    iload_flag_ff, ramp_flag_ff, temp_flag_ff};
  logic [15:0] rd_word;
  always_comb begin
    case (rd_sel)
      dccsr_pkg::DCCSR_REG_CODE: rd_word = code_ff;
      dccsr_pkg::DCCSR_REG_GAIN: rd_word = gain_ff;
      dccsr_pkg::DCCSR_REG_ZERO: rd_word = zero_ff;
      dccsr_pkg::DCCSR_REG_STAT: rd_word = status_word;
      dccsr_pkg::DCCSR_REG_CTRL: rd_word = ctrl_ff;
      dccsr_pkg::DCCSR_REG_CONF: rd_word = conf_ff;
      dccsr_pkg::DCCSR_REG_RST: rd_word = {15'h0000, soft_reset_ff};
      default: rd_word = 16'h0000;
    endcase
  end

  // Read response registered one cycle after the address is taken
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      rresp_ff <= `DCCSR_RESP_OKAY;
    end else if (s_axi_arvalid_i && !rvalid_ff) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= {16'h0000, rd_word};
      rresp_ff <= (rd_sel == dccsr_pkg::DCCSR_REG_NONE) ?
        `DCCSR_RESP_SLVERR : `DCCSR_RESP_OKAY;
    end else if (s_axi_rready_i) begin
      rvalid_ff <= 1'b0;
    end
  end

  // Output code: soft reset, direct write, or clear on range change
  logic [15:0] nxt_code;
  always_comb begin
    nxt_code = code_ff;
    if (soft_reset_ff) begin
      nxt_code = `DCCSR_CODE_RST;
    end else if (wr_code) begin
      nxt_code = wr_merged_code;
    end else if (range_chg) begin
      nxt_code = clear_code;
    end
  end

  // Soft reset trigger lasts one cycle and clears itself
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      soft_reset_ff <= 1'b0;
    end else begin
      soft_reset_ff <= soft_req && !soft_reset_ff;
    end
  end

  // Code, trims, control and configuration storage
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      code_ff <= `DCCSR_CODE_RST;
      gain_ff <= `DCCSR_GAIN_RST;
      zero_ff <= `DCCSR_ZERO_RST;
      ctrl_ff <= `DCCSR_CTRL_RST;
      conf_ff <= `DCCSR_CONF_RST;
    end else begin
      code_ff <= nxt_code;
      if (soft_reset_ff) begin
        gain_ff <= `DCCSR_GAIN_RST;
        zero_ff <= `DCCSR_ZERO_RST;
        ctrl_ff <= `DCCSR_CTRL_RST;
        conf_ff <= `DCCSR_CONF_RST;
      end else begin
        if (wr_gain) gain_ff <= wr_merged_gain;
        if (wr_zero) zero_ff <= wr_merged_zero;
        if (wr_ctrl) ctrl_ff <= new_ctrl;
        if (wr_conf) conf_ff <= new_conf;
      end
    end
  end

  // Fault and ramp flags; pulse events stick, levels track the monitor
  wire nxt_crc = frame_check_fault_i ||
    (crc_flag_ff && !soft_reset_ff);
  wire nxt_wd = watchdog_fault_i ||
    (wd_flag_ff && !soft_reset_ff);
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      crc_flag_ff <= 1'b0;
      wd_flag_ff <= 1'b0;
      iload_flag_ff <= 1'b0;
      ramp_flag_ff <= 1'b0;
      temp_flag_ff <= 1'b0;
    end else begin
      crc_flag_ff <= nxt_crc;
      wd_flag_ff <= nxt_wd;
      iload_flag_ff <= iload_sync && !soft_reset_ff;
      ramp_flag_ff <= ramp_active_i;
      temp_flag_ff <= temp_sync && !soft_reset_ff;
    end
  end

  // Gain and zero trim: code times (1 + gain/65536) plus signed zero
  wire [16:0] gain_scale = 17'h10000 + {1'b0, gain_ff};
  wire [32:0] trim_prod = {17'h00000, code_ff} * {16'h0000, gain_scale};
  wire [18:0] trim_sum = {2'b00, trim_prod[32:16]} +
    {{3{zero_ff[15]}}, zero_ff};
  wire [15:0] trim_sat = trim_sum[18] ? 16'h0000 :
    (|trim_sum[17:16]) ? 16'hFFFF : trim_sum[15:0];
  wire trim_en = conf_ff[`DCCSR_CONF_TRIM_EN];
  wire dual_en = conf_ff[`DCCSR_CONF_DUAL];

  // Trimmed code and current range are registered for the core
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      trimmed_ff <= `DCCSR_CODE_RST;
      cur_range_ff <= 2'h0;
    end else begin
      trimmed_ff <= (trim_en ? trim_sat : code_ff) & DATA_MASK;
      cur_range_ff <= dual_en ?
        conf_ff[`DCCSR_CONF_SPAN_MSB:`DCCSR_CONF_SPAN_LSB] :
        cur_range[1:0];
    end
  end

  // Register fields driven to the core
  assign output_code_bits_o = code_ff;
  assign trimmed_code_o = trimmed_ff;
  assign voltage_range_o = cur_range;
  assign current_range_o = cur_range_ff;
  assign both_outputs_enable_o = dual_en;
  assign output_enable_o = ctrl_ff[`DCCSR_CTRL_OUT_EN];
  assign sense_node_pulldown_o = conf_ff[`DCCSR_CONF_PULLDN];
  assign ramp_enable_o = ctrl_ff[`DCCSR_CTRL_RAMP_EN];
  assign ramp_clock_select_o =
    ctrl_ff[`DCCSR_CTRL_RCLK_MSB:`DCCSR_CTRL_RCLK_LSB];
  assign ramp_step_select_o =
    ctrl_ff[`DCCSR_CTRL_STEP_MSB:`DCCSR_CTRL_STEP_LSB];
  assign user_trim_enable_o = trim_en;
  assign frame_check_enable_o = conf_ff[`DCCSR_CONF_FCHK_EN];
  assign watchdog_enable_o = conf_ff[`DCCSR_CONF_WDOG_EN];
  assign watchdog_period_o =
    conf_ff[`DCCSR_CONF_WDPD_MSB:`DCCSR_CONF_WDPD_LSB];
  assign soft_reset_o = soft_reset_ff;

  // Checks on the register bank behaviour
  sequence s_soft_req;
    soft_req;
  endsequence
  sequence s_soft_done;
    soft_reset_ff ##1 (!soft_reset_ff && code_ff == 16'h0000 &&
      gain_ff == 16'h0000 && zero_ff == 16'h0000 && conf_ff == 16'h0000);
  endsequence

  property p_low_bits;
    LOW_RES |-> (code_ff[3:0] == 4'h0 && gain_ff[3:0] == 4'h0 &&
      zero_ff[3:0] == 4'h0);
  endproperty
  a_low_bits: assert property (p_low_bits)
    else $error("low bits held in low-resolution variant");

  property p_soft_reset;
    s_soft_req |=> s_soft_done;
  endproperty
  a_soft_reset: assert property (p_soft_reset)
    else $error("soft reset did not restore defaults");

  property p_soft_upper;
    (wr_rst && !wdata_ff[0]) |=> !soft_reset_ff;
  endproperty
  a_soft_upper: assert property (p_soft_upper)
    else $error("soft reset started without bit zero");

  property p_status_read;
    (s_axi_arvalid_i && !rvalid_ff &&
      rd_sel == dccsr_pkg::DCCSR_REG_STAT) |=> rdata_ff[31:5] == 27'h0;
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("status reserved bits not zero");

  property p_crc_sticky;
    (crc_flag_ff && !soft_reset_ff) |=> crc_flag_ff [*1];
  endproperty
  a_crc_sticky: assert property (p_crc_sticky)
    else $error("frame check flag dropped early");

  property p_wd_set;
    watchdog_fault_i |=> wd_flag_ff;
  endproperty
  a_wd_set: assert property (p_wd_set)
    else $error("watchdog flag not set");

  property p_temp_track;
    (temp_sync && !soft_reset_ff) |=> temp_flag_ff;
  endproperty
  a_temp_track: assert property (p_temp_track)
    else $error("overtemperature flag not reasserted");

  property p_iload_clear;
    !iload_sync |=> !iload_flag_ff;
  endproperty
  a_iload_clear: assert property (p_iload_clear)
    else $error("load flag stays after condition resolved");

  property p_ramp;
    ramp_active_i |=> status_word[1];
  endproperty
  a_ramp: assert property (p_ramp)
    else $error("ramp flag not following ramp");

  property p_range_clear;
    (range_chg && !soft_reset_ff) |=> code_ff == $past(clear_code);
  endproperty
  a_range_clear: assert property (p_range_clear)
    else $error("range change did not reload code");

  property p_span_keep;
    (wr_conf && !soft_reset_ff) |=> $stable(code_ff);
  endproperty
  a_span_keep: assert property (p_span_keep)
    else $error("configuration write altered code");

  property p_trim_bypass;
    !trim_en |=> trimmed_ff == $past(code_ff);
  endproperty
  a_trim_bypass: assert property (p_trim_bypass)
    else $error("trim applied while disabled");

  property p_dual;
    dual_en ##1 dual_en |-> current_range_o == $past(conf_ff[10:9]);
  endproperty
  a_dual: assert property (p_dual)
    else $error("current range not from span field");

  property p_status_ro;
    (wr_do && wr_sel == dccsr_pkg::DCCSR_REG_STAT) |=>
      ($stable(ctrl_ff) && $stable(conf_ff) && $stable(code_ff));
  endproperty
  a_status_ro: assert property (p_status_ro)
    else $error("status write had an effect");

endmodule : dccsr_top

/* dccsr_consts.svh */
// Register indices, field positions, reset values and bus answers
`ifndef DCCSR_CONSTS_SVH
`define DCCSR_CONSTS_SVH
// Register indices; byte address is four times the index
`define DCCSR_IDX_CODE 10'h010
`define DCCSR_IDX_GAIN 10'h011
`define DCCSR_IDX_ZERO 10'h012
`define DCCSR_IDX_STAT 10'h013
`define DCCSR_IDX_CTRL 10'h014
`define DCCSR_IDX_RST 10'h056
`define DCCSR_IDX_CONF 10'h057
// Reset values
`define DCCSR_CODE_RST 16'h0000
`define DCCSR_GAIN_RST 16'h0000
`define DCCSR_ZERO_RST 16'h0000
`define DCCSR_CTRL_RST 16'h0000
`define DCCSR_CONF_RST 16'h0000
// Data masks
`define DCCSR_LOW_RES_MASK 16'hFFF0
`define DCCSR_FULL_MASK 16'hFFFF
`define DCCSR_CTRL_WMASK 16'h9FF7
`define DCCSR_CONF_WMASK 16'h07BF
`define DCCSR_MIDSCALE 16'h8000
// Soft reset trigger bit
`define DCCSR_RST_BIT 0
// Control fields
`define DCCSR_CTRL_RANGE_MSB 2
`define DCCSR_CTRL_RANGE_LSB 0
`define DCCSR_CTRL_RAMP_EN 4
`define DCCSR_CTRL_STEP_MSB 7
`define DCCSR_CTRL_STEP_LSB 5
`define DCCSR_CTRL_RCLK_MSB 11
`define DCCSR_CTRL_RCLK_LSB 8
`define DCCSR_CTRL_OUT_EN 12
`define DCCSR_CTRL_CLR_BIT 15
// Configuration fields
`define DCCSR_CONF_SPAN_MSB 10
`define DCCSR_CONF_SPAN_LSB 9
`define DCCSR_CONF_DUAL 8
`define DCCSR_CONF_PULLDN 7
`define DCCSR_CONF_TRIM_EN 5
`define DCCSR_CONF_FCHK_EN 3
`define DCCSR_CONF_WDOG_EN 2
`define DCCSR_CONF_WDPD_MSB 1
`define DCCSR_CONF_WDPD_LSB 0
// Bus answers
`define DCCSR_RESP_OKAY 2'h0
`define DCCSR_RESP_SLVERR 2'h2
`endif

/* dccsr_pkg.sv */
// Types shared by the register bank
package dccsr_pkg;
  typedef enum logic [2:0] {
    DCCSR_REG_NONE = 3'b000,
    DCCSR_REG_CODE = 3'b001,
    DCCSR_REG_GAIN = 3'b010,
    DCCSR_REG_ZERO = 3'b011,
    DCCSR_REG_STAT = 3'b100,
    DCCSR_REG_CTRL = 3'b101,
    DCCSR_REG_CONF = 3'b110,
    DCCSR_REG_RST = 3'b111
  } dccsr_reg_e;
endpackage : dccsr_pkg

/* dccsr_mon_model.sv */
// Fault monitors and clear pin facing the register bank
`timescale 1ns/1ps
module dccsr_mon_model (
  // Clock and bench command
  input wire logic mclk_i,
  input wire logic [5:0] cmd_i,
  // Monitor levels
  output logic frame_check_fault_o,
  output logic watchdog_fault_o,
  output logic ramp_active_o,
  output logic current_load_fault_o,
  output logic overtemp_fault_o,
  output logic clear_level_pin_o
);
  logic [5:0] lvl_ff = 6'h00;
  // Each monitor follows its command one edge later
  always @(posedge mclk_i) begin
    lvl_ff <= cmd_i;
  end
  // Fan out the monitor levels
  assign frame_check_fault_o = lvl_ff[0];
  assign watchdog_fault_o = lvl_ff[1];
  assign ramp_active_o = lvl_ff[2];
  assign current_load_fault_o = lvl_ff[3];
  assign overtemp_fault_o = lvl_ff[4];
  assign clear_level_pin_o = lvl_ff[5];
endmodule : dccsr_mon_model

/* tb_top.sv */
// Self-checking bench for the register bank
`timescale 1ns/1ps
module tb_top;
  logic mclk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h00000000;
  logic awv = 1'b0;
  logic wv = 1'b0;
  logic arv = 1'b0;
  logic [5:0] cmd = 6'h00;
  logic awr, wrd, bv, arr, rv, ute;
  logic fcf, wdf, rmp, ldf, otf, clp;
  logic [1:0] bresp, rresp, cr, r, wdp;
  logic boe, oe, spd, rme, fce, wde, srt;
  logic [3:0] rcs;
  logic [31:0] rdata, d;
  logic [15:0] code, trim;
  logic [2:0] vr, rss;
  int fail_count = 0;
  int n_tests = 0;

  // Bench clock, 25 ns period
  always #12.5 mclk_i = ~mclk_i;

  dccsr_mon_model dccsr_mon_model_i (
    .mclk_i(mclk_i), .cmd_i(cmd), .frame_check_fault_o(fcf),
    .watchdog_fault_o(wdf), .ramp_active_o(rmp),
    .current_load_fault_o(ldf), .overtemp_fault_o(otf),
    .clear_level_pin_o(clp)
  );

  dccsr_top #(.LOW_RES(1'b1)) dccsr_top_i (
    .mclk_i(mclk_i), .reset_i(reset_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'h3), .s_axi_wvalid_i(wv),
    .s_axi_wready_o(wrd), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv),
    .s_axi_bready_i(1'b1), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arv),
    .s_axi_arready_o(arr), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rv), .s_axi_rready_i(1'b1),
    .frame_check_fault_i(fcf), .watchdog_fault_i(wdf),
    .ramp_active_i(rmp), .current_load_fault_i(ldf),
    .overtemp_fault_i(otf), .clear_level_pin_i(clp),
    .output_code_bits_o(code), .trimmed_code_o(trim),
    .voltage_range_o(vr), .current_range_o(cr),
    .both_outputs_enable_o(boe), .output_enable_o(oe),
    .sense_node_pulldown_o(spd), .ramp_enable_o(rme),
    .ramp_clock_select_o(rcs),
    .ramp_step_select_o(rss), .user_trim_enable_o(ute),
    .frame_check_enable_o(fce), .watchdog_enable_o(wde),
    .watchdog_period_o(wdp), .soft_reset_o(srt)
  );

  // Verdict and end of run
  task close_out;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : close_out

  // Compare seen against expected
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      $display("MISMATCH %s exp %h seen %h", nm, e, s);
      fail_count++;
    end
  endtask : chk

  // A bounded wait that ran out ends the run
  task tmo(input int n);
    if (n >= 40) begin
      fail_count++;
      close_out();
    end
  endtask : tmo

  // Write one register word and check the response
  task wr(input logic [11:0] a, input logic [15:0] v, input logic [1:0] e);
    int n;
    logic done;
    n = 0;
    done = 1'b0;
    awaddr <= a;
    wdata <= {16'h0000, v};
    awv <= 1'b1;
    wv <= 1'b1;
    while (!done && n < 40) begin
      @(posedge mclk_i);
      n++;
      if (awv && awr) awv <= 1'b0;
      if (wv && wrd) wv <= 1'b0;
      if (bv) begin
        done = 1'b1;
        chk("bresp", {30'h0, bresp}, {30'h0, e});
      end
    end
    tmo(n);
  endtask : wr

  // Read one register word
  task rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] q);
    int n;
    n = 0;
    v = 32'h0;
    q = 2'h3;
    araddr <= a;
    arv <= 1'b1;
    while (n < 40) begin
      @(posedge mclk_i);
      n++;
      if (arv && arr) arv <= 1'b0;
      if (rv) begin
        v = rdata;
        q = rresp;
        break;
      end
    end
    tmo(n);
  endtask : rd

  // Read and compare the data word
  task rc(input logic [11:0] a, input logic [15:0] e);
    rd(a, d, r);
    chk("rdata", d, {16'h0000, e});
  endtask : rc

  // Main sequence
  initial begin
    repeat (6) @(posedge mclk_i);
    reset_i <= 1'b0;
    @(posedge mclk_i);
    rc(12'h040, 16'h0000);
    rc(12'h044, 16'h0000);
    rc(12'h048, 16'h0000);
    rc(12'h04C, 16'h0000);
    // Code and trims keep bits 15:4 only
    for (int i = 0; i < 3; i++) begin
      wr(12'h040 + 12'(4 * i), 16'hA5A5, 2'h0);
      rc(12'h040 + 12'(4 * i), 16'hA5A0);
    end
    chk("code", {16'h0, code}, 32'hA5A0);
    // Status ignores writes
    wr(12'h04C, 16'hFFFF, 2'h0);
    rc(12'h04C, 16'h0000);
    // Unmapped index
    wr(12'h3FC, 16'h1234, 2'h2);
    rd(12'h3FC, d, r);
    chk("rresp", {30'h0, r}, 32'h2);
    chk("rdata", d, 32'h0);
    // Single output, config bits 10:7 left clear; range change clears code
    wr(12'h050, 16'h9FF1, 2'h0);
    rc(12'h040, 16'h8000);
    chk("crange", {30'h0, cr}, 32'h1);
    chk("ctrlout", {23'h0, oe, rme, rcs, rss}, 32'h1FF);
    // Dual outputs with current span 3
    wr(12'h15C, 16'h0700, 2'h0);
    rc(12'h040, 16'h8000);
    chk("crange", {30'h0, cr}, 32'h3);
    chk("vrange", {29'h0, vr}, 32'h1);
    // Trim applies only when enabled
    wr(12'h048, 16'h0010, 2'h0);
    repeat (2) @(posedge mclk_i);
    chk("trim", {16'h0, trim}, 32'h8000);
    wr(12'h15C, 16'h07AF, 2'h0);
    repeat (2) @(posedge mclk_i);
    // Gain A5A0 scales 8000 to D2D0, zero trim adds 0010
    chk("trim", {16'h0, trim}, 32'hD2E0);
    chk("trimen", {31'h0, ute}, 32'h1);
    chk("confout", {26'h0, boe, spd, fce, wde, wdp}, 32'h3F);
    // Level faults track their monitors
    cmd <= 6'b011100;
    repeat (6) @(posedge mclk_i);
    rc(12'h04C, 16'h0007);
    // Pulsed faults stay set, level faults drop when resolved
    cmd <= 6'b000011;
    @(posedge mclk_i);
    cmd <= 6'b000000;
    repeat (6) @(posedge mclk_i);
    rc(12'h04C, 16'h0018);
    // Reserved soft reset bits do nothing
    wr(12'h158, 16'hFFFE, 2'h0);
    rc(12'h04C, 16'h0018);
    rc(12'h040, 16'h8000);
    // Soft reset restores defaults and clears itself
    wr(12'h158, 16'h0001, 2'h0);
    repeat (2) @(posedge mclk_i);
    chk("srst", {31'h0, srt}, 32'h0);
    rc(12'h158, 16'h0000);
    rc(12'h04C, 16'h0000);
    rc(12'h040, 16'h0000);
    rc(12'h15C, 16'h0000);
    // Clear pin picks midscale for voltage ranges, zero for current ones
    cmd <= 6'b100000;
    wr(12'h040, 16'h1234, 2'h0);
    wr(12'h050, 16'h0002, 2'h0);
    rc(12'h040, 16'h8000);
    wr(12'h050, 16'h0005, 2'h0);
    rc(12'h040, 16'h0000);
    close_out();
  end
endmodule : tb_top
